// File: bdc_pkg.sv
// package: shared constants and types of the burst dram controller
package bdc_pkg;
   localparam int unsigned CLK_MHZ = 250;               // system clock rate
   localparam int unsigned REF_W = 8;                   // refresh timer width
   localparam logic [7:0] REF_RST = 8'h00;              // timer value after reset
   localparam int unsigned REF_MSB = 7;                 // timer msb position
   localparam logic [7:0] DRAM_WIN = 8'h01;             // top address digits of dram window
   localparam int unsigned WIN_LSB = 24;                // position of window digits
   localparam int unsigned ROW_LSB = 15;                // row address field position
   localparam int unsigned COL_LSB = 4;                 // column field above longword bits
   localparam int unsigned MA_W = 11;                   // multiplexed address width
   localparam logic [3:0] FIRST_CYC = 4'hd;             // first longword takes 14 clocks
   localparam logic [3:0] NEXT_CYC = 4'h6;              // later longwords take 7 clocks
   localparam logic [3:0] RAS_CYC = 4'h2;               // row strobe runs 3 clocks before mux
   localparam logic [3:0] MUX_CYC = 4'h1;               // mux runs 2 clocks before column strobe
   localparam logic [3:0] REFR_CYC = 4'h4;              // length of cbr refresh strobe
   localparam logic [3:0] WD_TRANS = 4'h9;              // ninth msb transition ends the wait
   localparam logic [1:0] BA_RST = 2'h0;                // burst counter value after reset
   localparam logic [1:0] REQ_IDLE = 2'b00;             // refresh machine codes
   localparam logic [1:0] REQ_REQ = 2'b01;
   localparam logic [1:0] REQ_WAIT = 2'b10;

   // processor bus inputs
   typedef struct packed {
      logic as_n;       // address strobe
      logic rd;         // read not write
      logic [1:0] siz;  // transfer size
      logic [31:0] addr;// byte address
   } bdc_cpu_t;

   // dram array outputs
   typedef struct packed {
      logic [3:0] ras_n;
      logic [3:0] cas_n;
      logic [MA_W-1:0] ma;
   } bdc_dram_t;

   typedef enum logic [2:0] {SQ_IDLE, SQ_RAS, SQ_MUX, SQ_CAS, SQ_BURST, SQ_REF,
                             SQ_HOLD} bdc_seq_t;
   typedef enum logic [1:0] {BC_IDLE, BC_WAIT, BC_TERM, BC_DONE} bdc_bst_t;
   typedef enum logic [1:0] {WD_IDLE, WD_COUNT, WD_TIMEOUT} bdc_wd_t;
endpackage

// File: bdc_burst_counter.sv
// module: two-bit burst longword address counter
`timescale 1ns/10ps
`default_nettype none
module bdc_burst_counter
(
   input wire logic clk_in,
   input wire logic nrst_in,
   input wire logic load_in,
   input wire logic inc_in,
   input wire logic [1:0] start_in,
   output logic [1:0] count_out
);
   // state of the counter
   typedef struct packed {
      logic [1:0] cnt;
   } bdc_cnt_state_t;
   bdc_cnt_state_t state_reg;
   bdc_cnt_state_t state_next;

   // load takes start plus one; increment wraps modulo four
   always_comb
   begin
      state_next = state_reg;
      if (load_in)
      begin
         state_next.cnt = start_in + 2'h1;
      end
      else if (inc_in)
      begin
         state_next.cnt = state_reg.cnt + 2'h1;
      end
   end

   // register with synchronous reset
   always_ff @(posedge clk_in)
   begin
      if (!nrst_in)
      begin
         state_reg.cnt <= bdc_pkg::BA_RST;
      end
      else
      begin
         state_reg <= state_next;
      end
   end

   assign count_out = state_reg.cnt;
endmodule // bdc_burst_counter
`default_nettype wire

// File: bdc_controller.sv
// module: burst dram controller top with sequencer, burst control, refresh and watchdog
`timescale 1ns/10ps
`default_nettype none
module bdc_controller
(
   input wire logic SYS_CLK_IN,           // inverted processor clock
   input wire logic NRST_IN,              // synchronous reset, active low
   input wire bdc_pkg::bdc_cpu_t CPU_IN,  // processor bus
   output logic BURST_ACK_N_OUT,          // synchronous burst acknowledge
   output logic SYNC_TERM_N_OUT,          // longword data available
   output logic BUS_ERR_N_OUT,            // watchdog bus error
   output logic REFRESH_TICK_OUT,         // refresh timer msb
   output bdc_pkg::bdc_dram_t DRAM_OUT    // strobes and multiplexed address
);
   // all state of the controller except the burst address counter in u_cnt
   typedef struct packed {
      logic [7:0] timer;
      logic [1:0] req_st;
      logic refresh_request;
      bdc_pkg::bdc_seq_t seq;
      logic [3:0] seq_cnt;
      logic row_col_done;
      bdc_pkg::bdc_bst_t bst;
      logic [3:0] wait_cnt;
      logic [1:0] beats;
      logic burst_sel;
      logic col_sel;
      bdc_pkg::bdc_wd_t wd;
      logic [3:0] wd_cnt;
      logic msb_d;
      logic burst_ack_n;
      logic sync_term_n;
      logic bus_err_n;
      logic tick;
      bdc_pkg::bdc_dram_t dram;
   } bdc_state_t;

   bdc_state_t state_reg;  // registered state
   bdc_state_t state_next; // next state
   logic access_request;   // decoded processor access
   logic cnt_load;         // burst counter load
   logic cnt_inc;          // burst counter increment
   logic [1:0] burst_addr_lsbs; // counter output
   logic [3:0] lane_cas;   // active-high byte lanes
   logic [1:0] a_lo;       // low address bits

   // dram window decode qualified by address strobe
   assign access_request = !CPU_IN.as_n &&
      (CPU_IN.addr[31:bdc_pkg::WIN_LSB] == bdc_pkg::DRAM_WIN);
   assign a_lo = CPU_IN.addr[1:0];

   // byte lane decode: size 01 byte, 10 word, 11 three bytes, 00 long
   always_comb
   begin
      lane_cas = 4'h0;
      if (CPU_IN.rd)
      begin
         lane_cas = 4'hf;
      end
      else
      begin
         unique case (CPU_IN.siz) // lane 0 is the most significant byte
            2'b01: lane_cas = 4'h1 << a_lo;
            2'b10: lane_cas = 4'(4'h3 << a_lo);
            2'b11: lane_cas = 4'(4'h7 << a_lo);
            2'b00: lane_cas = 4'(4'hf << a_lo); // misaligned long fills the rest
         endcase
      end
   end

   // burst address counter, steered by the burst controller
   bdc_burst_counter u_cnt
   (
      .clk_in(SYS_CLK_IN),
      .nrst_in(NRST_IN),
      .load_in(cnt_load),
      .inc_in(cnt_inc),
      .start_in(CPU_IN.addr[3:2]),
      .count_out(burst_addr_lsbs)
   );

   // next-state logic for every machine; one clock for all of them
   always_comb
   begin
      state_next = state_reg;
      cnt_load = 1'b0;
      cnt_inc = 1'b0;
      state_next.row_col_done = 1'b0;
      state_next.sync_term_n = 1'b1;

      // free running refresh timer, msb leaves as tick
      state_next.timer = state_reg.timer + 8'h01;
      state_next.tick = state_next.timer[bdc_pkg::REF_MSB];
      state_next.msb_d = state_reg.timer[bdc_pkg::REF_MSB];

      // refresh request machine, fixed codes
      unique case (state_reg.req_st)
         bdc_pkg::REQ_IDLE:
         begin
            if (state_reg.timer[bdc_pkg::REF_MSB])
            begin
               state_next.req_st = bdc_pkg::REQ_REQ;
               state_next.refresh_request = 1'b1;
            end
            else
            begin
               state_next.refresh_request = 1'b0;
            end
         end
         bdc_pkg::REQ_REQ:
         begin
            if (state_reg.seq == bdc_pkg::SQ_REF)
            begin
               state_next.req_st = bdc_pkg::REQ_WAIT;
               state_next.refresh_request = 1'b0;
            end
         end
         bdc_pkg::REQ_WAIT:
         begin
            state_next.refresh_request = 1'b0;
            if (!state_reg.timer[bdc_pkg::REF_MSB])
            begin
               state_next.req_st = bdc_pkg::REQ_IDLE;
            end
         end
         default:
         begin
            state_next.req_st = bdc_pkg::REQ_IDLE; // illegal code recovers
            state_next.refresh_request = 1'b0;
         end
      endcase

      // row/column strobe sequencer
      unique case (state_reg.seq)
         bdc_pkg::SQ_IDLE:
         begin
            state_next.dram.ras_n = 4'hf;
            state_next.dram.cas_n = 4'hf;
            state_next.col_sel = 1'b0;
            state_next.seq_cnt = 4'h0;
            if (state_reg.refresh_request)
            begin
               state_next.seq = bdc_pkg::SQ_REF; // refresh wins
               state_next.dram.cas_n = 4'h0; // column strobes first
            end
            else if (access_request)
            begin
               state_next.seq = bdc_pkg::SQ_RAS;
               state_next.dram.ras_n = 4'h0;
            end
         end
         bdc_pkg::SQ_RAS:
         begin
            state_next.seq_cnt = state_reg.seq_cnt + 4'h1;
            if (state_reg.seq_cnt == bdc_pkg::RAS_CYC)
            begin
               state_next.seq = bdc_pkg::SQ_MUX; // row latched, switch to column
               state_next.col_sel = 1'b1;
               state_next.seq_cnt = 4'h0;
            end
         end
         bdc_pkg::SQ_MUX:
         begin
            state_next.seq_cnt = state_reg.seq_cnt + 4'h1;
            if (state_reg.seq_cnt == bdc_pkg::MUX_CYC)
            begin
               state_next.seq = bdc_pkg::SQ_CAS;
               state_next.dram.cas_n = ~lane_cas;
               state_next.row_col_done = 1'b1;
            end
         end
         bdc_pkg::SQ_CAS:
         begin
            if (CPU_IN.as_n)
            begin
               state_next.seq = bdc_pkg::SQ_IDLE;
               state_next.dram.ras_n = 4'hf; // release at once, no stray strobe
               state_next.dram.cas_n = 4'hf;
            end
            else if (state_reg.burst_sel)
            begin
               state_next.seq = bdc_pkg::SQ_BURST;
               state_next.dram.cas_n = 4'hf; // precharge before the second longword
            end
         end
         bdc_pkg::SQ_BURST:
         begin
            state_next.dram.cas_n = state_reg.sync_term_n ? ~lane_cas : 4'hf;
            if (CPU_IN.as_n)
            begin
               state_next.seq = bdc_pkg::SQ_IDLE; // early end allowed
               state_next.dram.ras_n = 4'hf; // no column strobe on released lines
               state_next.dram.cas_n = 4'hf;
            end
         end
         bdc_pkg::SQ_REF:
         begin
            state_next.seq_cnt = state_reg.seq_cnt + 4'h1;
            state_next.dram.ras_n = 4'h0; // all rows after columns
            if (state_reg.seq_cnt == bdc_pkg::REFR_CYC)
            begin
               state_next.seq = bdc_pkg::SQ_HOLD;
               state_next.dram.ras_n = 4'hf;
               state_next.dram.cas_n = 4'hf;
            end
         end
         bdc_pkg::SQ_HOLD:
         begin
            state_next.seq = bdc_pkg::SQ_IDLE; // precharge gap
         end
         default:
         begin
            state_next.seq = bdc_pkg::SQ_IDLE;
         end
      endcase

      // burst controller
      unique case (state_reg.bst)
         bdc_pkg::BC_IDLE:
         begin
            state_next.burst_ack_n = 1'b1;
            state_next.burst_sel = 1'b0;
            state_next.beats = 2'h0;
            if (state_reg.row_col_done)
            begin
               state_next.bst = bdc_pkg::BC_WAIT;
               state_next.burst_ack_n = 1'b0;
               state_next.wait_cnt = bdc_pkg::FIRST_CYC - 4'h7; // 14 from the take
            end
         end
         bdc_pkg::BC_WAIT:
         begin
            state_next.wait_cnt = state_reg.wait_cnt - 4'h1; // wait states
            if (CPU_IN.as_n)
            begin
               state_next.bst = bdc_pkg::BC_DONE;
            end
            else if (state_reg.wait_cnt == 4'h0)
            begin
               state_next.bst = bdc_pkg::BC_TERM;
               state_next.sync_term_n = 1'b0;
            end
         end
         bdc_pkg::BC_TERM:
         begin
            state_next.beats = state_reg.beats + 2'h1;
            state_next.wait_cnt = bdc_pkg::NEXT_CYC - 4'h1;
            if (state_reg.beats == 2'h0)
            begin
               cnt_load = 1'b1;
               state_next.burst_sel = 1'b1;
            end
            else
            begin
               cnt_inc = 1'b1;
            end
            if (state_reg.beats == 2'h3)
            begin
               state_next.bst = bdc_pkg::BC_DONE;
            end
            else
            begin
               state_next.bst = bdc_pkg::BC_WAIT;
            end
         end
         bdc_pkg::BC_DONE:
         begin
            state_next.burst_ack_n = 1'b1;
            state_next.burst_sel = 1'b0;
            if (CPU_IN.as_n)
            begin
               state_next.bst = bdc_pkg::BC_IDLE;
            end
         end
      endcase

      // address mux: row, then column with burst lsbs once bursting
      if (state_next.col_sel)
      begin
         state_next.dram.ma = {CPU_IN.addr[12:bdc_pkg::COL_LSB],
            (state_next.burst_sel ? burst_addr_lsbs : CPU_IN.addr[3:2])};
      end
      else
      begin
         state_next.dram.ma = CPU_IN.addr[25:bdc_pkg::ROW_LSB];
      end

      // bus error watchdog counts msb edges while strobe held
      unique case (state_reg.wd)
         bdc_pkg::WD_IDLE:
         begin
            state_next.bus_err_n = 1'b1;
            state_next.wd_cnt = 4'h0;
            if (!CPU_IN.as_n)
            begin
               state_next.wd = bdc_pkg::WD_COUNT;
            end
         end
         bdc_pkg::WD_COUNT:
         begin
            if (CPU_IN.as_n)
            begin
               state_next.wd = bdc_pkg::WD_IDLE;
            end
            else if (state_reg.msb_d != state_reg.timer[bdc_pkg::REF_MSB])
            begin
               state_next.wd_cnt = state_reg.wd_cnt + 4'h1;
               if (state_reg.wd_cnt == bdc_pkg::WD_TRANS - 4'h1)
               begin
                  state_next.wd = bdc_pkg::WD_TIMEOUT;
                  state_next.bus_err_n = 1'b0;
               end
            end
         end
         bdc_pkg::WD_TIMEOUT:
         begin
            if (CPU_IN.as_n)
            begin
               state_next.wd = bdc_pkg::WD_IDLE; // error holds until cycle ends
               state_next.bus_err_n = 1'b1;
            end
         end
         default:
         begin
            state_next.wd = bdc_pkg::WD_IDLE;
         end
      endcase
   end

   // register all state; timer restarts at reset so watchdog timing is repeatable
   always_ff @(posedge SYS_CLK_IN)
   begin
      if (!NRST_IN)
      begin
         state_reg <= '0;
         state_reg.timer <= bdc_pkg::REF_RST;
         state_reg.req_st <= bdc_pkg::REQ_IDLE;
         state_reg.seq <= bdc_pkg::SQ_IDLE;
         state_reg.bst <= bdc_pkg::BC_IDLE;
         state_reg.wd <= bdc_pkg::WD_IDLE;
         state_reg.burst_ack_n <= 1'b1;
         state_reg.sync_term_n <= 1'b1;
         state_reg.bus_err_n <= 1'b1;
         state_reg.dram.ras_n <= 4'hf;
         state_reg.dram.cas_n <= 4'hf;
      end
      else
      begin
         state_reg <= state_next;
      end
   end

   // outputs straight from flip-flops
   assign BURST_ACK_N_OUT = state_reg.burst_ack_n;
   assign SYNC_TERM_N_OUT = state_reg.sync_term_n;
   assign BUS_ERR_N_OUT = state_reg.bus_err_n;
   assign REFRESH_TICK_OUT = state_reg.tick;
   assign DRAM_OUT = state_reg.dram;
endmodule // bdc_controller
`default_nettype wire

// File: bdc_controller_monitor.sv
// checker: concurrent assertions on the controller ports
`timescale 1ns/10ps
`default_nettype none
module bdc_controller_monitor
(
   input wire logic SYS_CLK_IN,
   input wire logic NRST_IN,
   input wire bdc_pkg::bdc_cpu_t CPU_IN,
   input wire logic BURST_ACK_N_OUT,
   input wire logic SYNC_TERM_N_OUT,
   input wire logic BUS_ERR_N_OUT,
   input wire logic REFRESH_TICK_OUT,
   input wire bdc_pkg::bdc_dram_t DRAM_OUT
);
   default clocking cb @(posedge SYS_CLK_IN); endclocking
   default disable iff (!NRST_IN);
   logic [7:0] tmr_reg; // mirror of the free refresh timer
   logic [10:0] low_reg; // cycles with address strobe held low, saturating
   logic [3:0] cas_reg; // column strobes one cycle back
   logic [3:0] ras_reg; // row strobes one cycle back
   logic seen_reg; // a refresh already ran in this high phase
   logic [3:0] base; // byte count as a lane mask
   logic [7:0] wide; // shifted mask, spill beyond the longword dropped
   logic acc_go; // row strobe opens a processor access
   logic ref_go; // column strobes first open a refresh
   // lanes a write touches follow size and the low address bits
   always_comb
   begin
      base = (CPU_IN.siz == 2'h0) ? 4'hf : 4'((5'h1 << CPU_IN.siz) - 5'h1);
      wide = {4'h0, base} << CPU_IN.addr[1:0];
      acc_go = (&ras_reg) && (DRAM_OUT.ras_n != 4'hf) && (&DRAM_OUT.cas_n);
      ref_go = (&cas_reg) && (DRAM_OUT.cas_n == 4'h0) && (&DRAM_OUT.ras_n);
   end
   // helper history; strobes reset high to match the idle array
   always_ff @(posedge SYS_CLK_IN)
   begin
      if (!NRST_IN)
      begin
         tmr_reg <= 8'h00;
         low_reg <= 11'h000;
         cas_reg <= 4'hf;
         ras_reg <= 4'hf;
         seen_reg <= 1'b0;
      end
      else
      begin
         tmr_reg <= tmr_reg + 8'h01;
         low_reg <= CPU_IN.as_n ? 11'h000 : ((&low_reg) ? low_reg : low_reg + 11'h001);
         cas_reg <= DRAM_OUT.cas_n;
         ras_reg <= DRAM_OUT.ras_n;
         seen_reg <= REFRESH_TICK_OUT & (seen_reg | ref_go);
      end
   end
   a_row_col_order: assert property (acc_go |-> ##1 (DRAM_OUT.ma == CPU_IN.addr[25:15])
      ##2 (DRAM_OUT.ma[10:2] == CPU_IN.addr[12:4]) ##2 (DRAM_OUT.cas_n != 4'hf))
      else $error("row and column strobe order broken");
   a_write_lanes: assert property ((&cas_reg) && (DRAM_OUT.cas_n != 4'hf)
      && (DRAM_OUT.ras_n != 4'hf) && !CPU_IN.rd |-> DRAM_OUT.cas_n == ~wide[3:0])
      else $error("write strobes wrong byte lanes");
   a_read_lanes: assert property ((&cas_reg) && (DRAM_OUT.cas_n != 4'hf)
      && (DRAM_OUT.ras_n != 4'hf) && CPU_IN.rd |-> DRAM_OUT.cas_n == 4'h0)
      else $error("read does not strobe all lanes");
   a_refresh_all: assert property (ref_go |-> ##[1:4] (DRAM_OUT.ras_n == 4'h0))
      else $error("refresh misses row strobes");
   a_refresh_once: assert property (ref_go |-> REFRESH_TICK_OUT && !seen_reg)
      else $error("refresh outside one per high phase");
   a_refresh_prompt: assert property ($rose(REFRESH_TICK_OUT) |-> ##[1:60] ref_go)
      else $error("refresh not started");
   a_ack_start: assert property (acc_go |-> BURST_ACK_N_OUT [*5] ##[0:2] !BURST_ACK_N_OUT)
      else $error("burst acknowledge timing wrong");
   a_term_gap: assert property ($fell(SYNC_TERM_N_OUT) |-> ##1 SYNC_TERM_N_OUT [*6])
      else $error("terminations closer than seven clocks");
   a_burst_exit: assert property ($rose(CPU_IN.as_n) |-> ##[1:3] (BURST_ACK_N_OUT && SYNC_TERM_N_OUT))
      else $error("burst not left on strobe negation");
   a_tick_timer: assert property (REFRESH_TICK_OUT == tmr_reg[7])
      else $error("refresh tick off the free timer");
   a_err_not_early: assert property ($fell(BUS_ERR_N_OUT) |-> low_reg >= 11'h400)
      else $error("bus error too early");
   a_err_by_limit: assert property (!CPU_IN.as_n && low_reg == 11'h488 |-> !BUS_ERR_N_OUT)
      else $error("bus error too late");
   a_err_release: assert property (CPU_IN.as_n && $past(CPU_IN.as_n) |-> BUS_ERR_N_OUT)
      else $error("bus error without held strobe");
endmodule // bdc_controller_monitor
bind bdc_controller bdc_controller_monitor mon_u (.SYS_CLK_IN(SYS_CLK_IN), .NRST_IN(NRST_IN),
   .CPU_IN(CPU_IN), .BURST_ACK_N_OUT(BURST_ACK_N_OUT), .SYNC_TERM_N_OUT(SYNC_TERM_N_OUT),
   .BUS_ERR_N_OUT(BUS_ERR_N_OUT), .REFRESH_TICK_OUT(REFRESH_TICK_OUT), .DRAM_OUT(DRAM_OUT));
`default_nettype wire

// File: bdc_cpu_model.sv
// partner: processor bus master running one bus cycle per start pulse
`timescale 1ns/10ps
`default_nettype none
module bdc_cpu_model
(
   input wire logic clk_in,
   input wire logic nrst_in,
   input wire logic go_in, // start a cycle when idle
   input wire logic rd_in,
   input wire logic [1:0] siz_in,
   input wire logic [31:0] addr_in,
   input wire logic [2:0] terms_in, // longwords taken before ending
   input wire logic [11:0] hold_in, // give up after this many cycles
   input wire logic term_n_in,
   output bdc_pkg::bdc_cpu_t cpu_out,
   output logic done_out
);
   logic busy_reg; // address strobe held
   logic [2:0] got_reg; // terminations seen
   logic [11:0] wait_reg; // cycles since start
   // one bus cycle; an early end models a processor quitting mid-burst
   always_ff @(posedge clk_in)
   begin
      done_out <= 1'b0;
      if (!nrst_in)
      begin
         busy_reg <= 1'b0;
         cpu_out <= {1'b1, 35'h0};
      end
      else if (!busy_reg)
      begin
         if (go_in)
         begin
            cpu_out <= {1'b0, rd_in, siz_in, addr_in};
            busy_reg <= 1'b1;
            got_reg <= 3'h0;
            wait_reg <= 12'h000;
         end
         else
         begin
            // released lines flip each cycle so a stale value never looks valid
            cpu_out <= {1'b1, ~cpu_out[34:0]};
         end
      end
      else
      begin
         wait_reg <= wait_reg + 12'h001;
         if (!term_n_in)
            got_reg <= got_reg + 3'h1;
         if ((!term_n_in && (got_reg + 3'h1) == terms_in) || wait_reg == hold_in)
         begin
            cpu_out.as_n <= 1'b1;
            busy_reg <= 1'b0;
            done_out <= 1'b1;
         end
      end
   end
endmodule // bdc_cpu_model
`default_nettype wire

// File: testbench.sv
// testbench: bursts, writes, aborts, refresh and watchdog on the controller
`timescale 1ns/10ps
`default_nettype none
module testbench;
   logic clk, nrst, go, rd, done, ack_n, term_n, err_n, tick, err_seen;
   logic [1:0] siz;
   logic [2:0] terms;
   logic [11:0] hold;
   logic [31:0] addr, a, lfsr;
   logic [3:0] cas_first, ras_prev, cas_prev;
   bdc_pkg::bdc_cpu_t cpu;
   bdc_pkg::bdc_dram_t dram;
   int bad_count, total_checks, cyc, t0, n_acc, n_ref, rises;
   int term_at[$]; // termination times from the row strobe
   logic [1:0] lsb_q[$]; // low column bits at each column strobe
   bdc_controller dut_u (.SYS_CLK_IN(clk), .NRST_IN(nrst), .CPU_IN(cpu), .BURST_ACK_N_OUT(ack_n),
      .SYNC_TERM_N_OUT(term_n), .BUS_ERR_N_OUT(err_n), .REFRESH_TICK_OUT(tick), .DRAM_OUT(dram));
   bdc_cpu_model cpu_u (.clk_in(clk), .nrst_in(nrst), .go_in(go), .rd_in(rd), .siz_in(siz),
      .addr_in(addr), .terms_in(terms), .hold_in(hold), .term_n_in(term_n), .cpu_out(cpu),
      .done_out(done));
   initial
   begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   // lfsr step for repeatable addresses
   function automatic logic [31:0] next_rand(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction
   // column strobes expected for a write of this size and offset
   function automatic logic [3:0] exp_cas(input logic [1:0] s, input logic [1:0] off);
      logic [7:0] m;
      m = {4'h0, (s == 2'h0) ? 4'hf : 4'((5'h1 << s) - 5'h1)} << off;
      return ~m[3:0];
   endfunction
   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   // watches strobes; refresh opens with column strobes, so it is not an access
   always @(posedge clk)
   begin
      cyc++;
      if (cyc > 20000)
      begin
         bad_count++;
         end_of_test();
      end
      if (&ras_prev && dram.ras_n != 4'hf && &dram.cas_n)
      begin
         n_acc++;
         t0 = cyc;
      end
      if (&cas_prev && dram.cas_n != 4'hf && dram.ras_n != 4'hf)
      begin
         lsb_q.push_back(dram.ma[1:0]);
         if (lsb_q.size() == 1)
            cas_first = dram.cas_n;
      end
      if (&cas_prev && dram.cas_n == 4'h0 && &dram.ras_n)
         n_ref++;
      if (term_n === 1'b0)
         term_at.push_back(cyc - t0);
      if (err_n === 1'b0)
         err_seen = 1'b1;
      ras_prev = dram.ras_n;
      cas_prev = dram.cas_n;
   end
   always @(posedge tick)
      rises++;
   // one bus cycle through the processor model, bounded wait for its end
   task automatic run(input logic r, input logic [1:0] s, input logic [31:0] ad,
                      input logic [2:0] nt, input logic [11:0] h);
      int k;
      lsb_q.delete();
      term_at.delete();
      n_acc = 0;
      err_seen = 1'b0;
      @(posedge clk);
      go <= 1'b1;
      rd <= r;
      siz <= s;
      addr <= ad;
      terms <= nt;
      hold <= h;
      @(posedge clk);
      go <= 1'b0;
      k = 0;
      while (done !== 1'b1 && k < 4000)
      begin
         @(posedge clk);
         k++;
      end
      check("done", done, 1'b1);
      repeat (4) @(posedge clk);
   endtask
   initial
   begin
      {go, rd, siz, terms, hold, addr, nrst} = '0;
      {bad_count, total_checks, cyc, t0, n_ref, rises} = '0;
      ras_prev = 4'hf;
      cas_prev = 4'hf;
      lfsr = 32'ha705;
      repeat (3) @(posedge clk);
      nrst <= 1'b1;
      // bursts: aligned line, entry at the last longword, then random starts
      for (int i = 0; i < 6; i++)
      begin
         lfsr = next_rand(lfsr);
         a = {8'h01, lfsr[23:4], (i == 0) ? 2'h0 : (i == 1) ? 2'h3 : lfsr[3:2], 2'h0};
         run(1'b1, 2'h0, a, 3'h4, 12'd300);
         check("access", n_acc, 1);
         check("rd_cas", cas_first, 4'h0);
         for (int j = 0; j < 4; j++)
         begin
            check("col_lsb", lsb_q[j], 2'(a[3:2] + j));
            check("term_at", term_at[j], 13 + 7 * j);
         end
      end
      // every size at every byte offset
      for (int i = 0; i < 16; i++)
      begin
         lfsr = next_rand(lfsr);
         a = {8'h01, lfsr[23:0]};
         a[1:0] = 2'(i);
         run(1'b0, 2'(i >> 2), a, 3'h1, 12'd300);
         check("wr_cas", cas_first, exp_cas(2'(i >> 2), 2'(i)));
      end
      // processor quits after two longwords
      run(1'b1, 2'h0, {8'h01, lfsr[23:0]}, 3'h2, 12'd300);
      check("abort_terms", term_at.size(), 2);
      check("abort_ack", ack_n, 1'b1);
      // stalled strobe outside the window, long then short
      run(1'b1, 2'h0, 32'h0200_0000, 3'h4, 12'd1300);
      check("wd_err", err_seen, 1'b1);
      check("no_access", n_acc, 0);
      check("err_drop", err_n, 1'b1);
      run(1'b1, 2'h0, 32'h0000_1000, 3'h4, 12'd900);
      check("wd_quiet", err_seen, 1'b0);
      check("refreshes", (rises - n_ref) inside {0, 1}, 1'b1);
      end_of_test();
   end
endmodule // testbench
`default_nettype wire
